//--- logic/pmsb_regs.sv
// Overview of operation
// - Status bit 0 reads 1 while the die is above the hot threshold, else 0.
// - Each shutdown cause flag at bits 2:0 is set by the device and cleared by a 1 write.
// - The cold-off flag at bit 3 is never set and always reads 0.
// - A supply undervoltage shutdown sets the cause flag at bit 2.
// - An unmasked rail power fault shutdown sets the cause flag at bit 1.
// - A critical temperature shutdown sets the cause flag at bit 0.
// - Any of those three flags becoming set also sets the shutdown indicator.
// - Bits 7:1 of the first controller register hold its voltage code.
// - Bits 7:1 of the second controller register hold its voltage code.
// - Each voltage code is read on a 10 mV or a 25 mV step range.
// - Decay bit 0 slews down actively, 1 lets the output decay passively.
// - The shutdown indicator clears only once all cause flags are clear.
// - The shutdown indicator mask at bit 3 resets to masked, 1 is masked.
`timescale 1ns/10ps
`include "pmsb_map.svh"

module pmsb_regs #(
  parameter int SLEW_STEP_CYC = `PMSB_SLEW_STEP_CYC,
  parameter logic [11:0] FINE_BASE_MV = 12'h000,
  parameter logic [11:0] COARSE_BASE_MV = 12'h000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register access
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Device conditions
  input wire logic die_hot,
  input wire pmsb_pkg::pmsb_evt_s shutdown_evt,
  input wire logic rail_fault_masked,
  input wire logic one_coarse_range,
  input wire logic two_coarse_range,
  // Shutdown reporting
  output logic shutdown_indicator,
  output logic shutdown_irq,
  // Controllers
  output pmsb_pkg::pmsb_rail_s controller_one_voltage,
  output pmsb_pkg::pmsb_rail_s controller_two_voltage,
  output pmsb_pkg::pmsb_rail_out_s controller_one_rail,
  output pmsb_pkg::pmsb_rail_out_s controller_two_rail,
  output logic [7:0] controller_three_decay
);

  localparam int DIV_W = $clog2(SLEW_STEP_CYC + 1);

  // Register state
  logic die_hot_status_bit;
  logic [2:0] cause;
  logic [7:0] irq_mask;
  logic [7:0] next_rdata;
  logic next_rvalid;
  logic next_die_hot;
  logic [2:0] next_cause;
  logic next_indicator;
  logic next_irq;
  logic [7:0] next_mask;
  logic [7:0] next_three;
  logic [2:0] cause_set;
  logic [DIV_W-1:0] div_cnt;
  logic [DIV_W-1:0] next_div_cnt;
  logic step_en;
  logic next_step_en;
  logic wr_one;
  logic wr_two;

  // Bus lines are arguments so continuous callers track them
  function automatic logic hit(input logic wr, input logic [7:0] addr,
    input logic [7:0] off);
    hit = wr && (addr == off);
  endfunction

  assign wr_one = hit(reg_wr, reg_addr, `PMSB_OFF_CTRL_ONE);
  assign wr_two = hit(reg_wr, reg_addr, `PMSB_OFF_CTRL_TWO);

  // Slew step divider
  always_comb begin
    next_div_cnt = div_cnt + DIV_W'(1);
    next_step_en = 1'b0;
    if (div_cnt == DIV_W'(SLEW_STEP_CYC - 1)) begin
      next_div_cnt = '0;
      next_step_en = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_cnt <= '0;
      step_en <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      step_en <= next_step_en;
    end
  end

  // Status, cause and shutdown indicator
  always_comb begin
    next_die_hot = die_hot;
    cause_set[`PMSB_BIT_SUPPLY_UV] = shutdown_evt.supply_uv;
    cause_set[`PMSB_BIT_RAIL_FAULT] = shutdown_evt.rail_fault
      && !rail_fault_masked;
    cause_set[`PMSB_BIT_CRIT_TEMP] = shutdown_evt.crit_temp;
    next_cause = cause;
    if (hit(reg_wr, reg_addr, `PMSB_OFF_CAUSE)) begin
      next_cause = cause & ~reg_wdata[2:0];
    end
    next_cause = next_cause | cause_set;
    next_indicator = shutdown_indicator;
    if (hit(reg_wr, reg_addr, `PMSB_OFF_IRQ)
        && reg_wdata[`PMSB_BIT_SHUTDOWN] && (cause == 3'h0)) begin
      next_indicator = 1'b0;
    end
    if ((cause_set & ~cause) != 3'h0) begin
      next_indicator = 1'b1;
    end
    next_mask = irq_mask;
    if (hit(reg_wr, reg_addr, `PMSB_OFF_IRQ_MASK)) begin
      // Reserved mask bits stay at their reset ones
      next_mask = (reg_wdata & `PMSB_MASK_RW_BITS)
        | (`PMSB_RST_IRQ_MASK & ~`PMSB_MASK_RW_BITS);
    end
    next_irq = next_indicator && !next_mask[`PMSB_BIT_SHUTDOWN];
    next_three = controller_three_decay;
    if (hit(reg_wr, reg_addr, `PMSB_OFF_CTRL_THREE)) begin
      next_three = reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      die_hot_status_bit <= 1'b0;
      cause <= 3'h0;
      shutdown_indicator <= 1'b0;
      shutdown_irq <= 1'b0;
      irq_mask <= `PMSB_RST_IRQ_MASK;
      controller_three_decay <= `PMSB_RST_CTRL;
    end else begin
      die_hot_status_bit <= next_die_hot;
      cause <= next_cause;
      shutdown_indicator <= next_indicator;
      shutdown_irq <= next_irq;
      irq_mask <= next_mask;
      controller_three_decay <= next_three;
    end
  end

  // Read path, unmapped offsets read zero
  always_comb begin
    next_rdata = 8'h00;
    next_rvalid = reg_rd;
    if (reg_rd) begin
      case (reg_addr)
        `PMSB_OFF_IRQ: begin
          next_rdata[`PMSB_BIT_SHUTDOWN] = shutdown_indicator;
        end
        `PMSB_OFF_IRQ_MASK: begin
          next_rdata = irq_mask;
        end
        `PMSB_OFF_STATUS: begin
          next_rdata[`PMSB_BIT_DIE_HOT] = die_hot_status_bit;
        end
        `PMSB_OFF_CAUSE: begin
          next_rdata = {5'h00, cause};
        end
        `PMSB_OFF_CTRL_ONE: begin
          next_rdata = controller_one_voltage;
        end
        `PMSB_OFF_CTRL_TWO: begin
          next_rdata = controller_two_voltage;
        end
        `PMSB_OFF_CTRL_THREE: begin
          next_rdata = controller_three_decay;
        end
        default: begin
          next_rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rdata <= next_rdata;
      reg_rvalid <= next_rvalid;
    end
  end

  pmsb_rail #(
    .RESET_VALUE(`PMSB_RST_CTRL),
    .FINE_BASE_MV(FINE_BASE_MV),
    .COARSE_BASE_MV(COARSE_BASE_MV)
  ) u_rail_one (
    .clk(clk),
    .nrst(nrst),
    .step_en(step_en),
    .wr(wr_one),
    .wdata(reg_wdata),
    .coarse_range(one_coarse_range),
    .ctrl(controller_one_voltage),
    .rail(controller_one_rail)
  );

  pmsb_rail #(
    .RESET_VALUE(`PMSB_RST_CTRL),
    .FINE_BASE_MV(FINE_BASE_MV),
    .COARSE_BASE_MV(COARSE_BASE_MV)
  ) u_rail_two (
    .clk(clk),
    .nrst(nrst),
    .step_en(step_en),
    .wr(wr_two),
    .wdata(reg_wdata),
    .coarse_range(two_coarse_range),
    .ctrl(controller_two_voltage),
    .rail(controller_two_rail)
  );

endmodule // pmsb_regs

//--- logic/pmsb_map.svh
`ifndef PMSB_MAP_SVH
`define PMSB_MAP_SVH

// Register offsets
`define PMSB_OFF_IRQ 8'h02
`define PMSB_OFF_IRQ_MASK 8'h03
`define PMSB_OFF_STATUS 8'h04
`define PMSB_OFF_CAUSE 8'h05
`define PMSB_OFF_CTRL_ONE 8'h20
`define PMSB_OFF_CTRL_TWO 8'h21
`define PMSB_OFF_CTRL_THREE 8'h22

// Field positions
`define PMSB_BIT_DIE_HOT 0
`define PMSB_BIT_CRIT_TEMP 0
`define PMSB_BIT_RAIL_FAULT 1
`define PMSB_BIT_SUPPLY_UV 2
`define PMSB_BIT_COLD_OFF 3
`define PMSB_BIT_SHUTDOWN 3
`define PMSB_BIT_DECAY 0
`define PMSB_CODE_MSB 7
`define PMSB_CODE_LSB 1

// Reset values
`define PMSB_RST_STATUS 8'h00
`define PMSB_RST_CAUSE 8'h00
`define PMSB_RST_IRQ 8'h00
`define PMSB_RST_IRQ_MASK 8'hff
`define PMSB_RST_CTRL 8'h00
`define PMSB_MASK_RW_BITS 8'h89
`define PMSB_CAUSE_CLR_BITS 8'h07

// Voltage steps in mV
`define PMSB_STEP_FINE_MV 12'h00a
`define PMSB_STEP_COARSE_MV 12'h019

// Slew step period
`define PMSB_SLEW_STEP_NS 1000
`define PMSB_CLK_PERIOD_NS 10
`define PMSB_SLEW_STEP_CYC (`PMSB_SLEW_STEP_NS / `PMSB_CLK_PERIOD_NS)

`endif

//--- logic/pmsb_pkg.sv
package pmsb_pkg;

  typedef struct packed {
    logic supply_uv;
    logic rail_fault;
    logic crit_temp;
  } pmsb_evt_s;

  typedef struct packed {
    logic [6:0] code;
    logic decay;
  } pmsb_rail_s;

  typedef struct packed {
    logic [6:0] applied_code;
    logic [11:0] out_mv;
    logic slewing;
  } pmsb_rail_out_s;

endpackage

//--- logic/pmsb_rail.sv
`timescale 1ns/10ps
`include "pmsb_map.svh"

module pmsb_rail #(
  parameter logic [7:0] RESET_VALUE = `PMSB_RST_CTRL,
  parameter logic [11:0] FINE_BASE_MV = 12'h000,
  parameter logic [11:0] COARSE_BASE_MV = 12'h000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Control
  input wire logic step_en,
  input wire logic wr,
  input wire logic [7:0] wdata,
  input wire logic coarse_range,
  // State
  output pmsb_pkg::pmsb_rail_s ctrl,
  output pmsb_pkg::pmsb_rail_out_s rail
);

  pmsb_pkg::pmsb_rail_s next_ctrl;
  pmsb_pkg::pmsb_rail_out_s next_rail;
  logic [6:0] next_code;

  always_comb begin
    next_ctrl = ctrl;
    if (wr) begin
      next_ctrl = wdata;
    end
    next_code = rail.applied_code;
    if (ctrl.code > rail.applied_code) begin
      next_code = ctrl.code;
    end else if (ctrl.code < rail.applied_code) begin
      if (ctrl.decay) begin
        next_code = ctrl.code;
      end else if (step_en) begin
        next_code = rail.applied_code - 7'h01;
      end
    end
    next_rail.applied_code = next_code;
    next_rail.slewing = !ctrl.decay && (ctrl.code < next_code);
    if (coarse_range) begin
      next_rail.out_mv = COARSE_BASE_MV
        + 12'(next_code * `PMSB_STEP_COARSE_MV);
    end else begin
      next_rail.out_mv = FINE_BASE_MV + 12'(next_code * `PMSB_STEP_FINE_MV);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= RESET_VALUE;
      rail <= '0;
    end else begin
      ctrl <= next_ctrl;
      rail <= next_rail;
    end
  end

endmodule // pmsb_rail

//--- verification/pmsb_regs_asserts.sv
`timescale 1ns/10ps
module pmsb_regs_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Bus and conditions
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic die_hot,
  input wire pmsb_pkg::pmsb_evt_s shutdown_evt,
  input wire logic rail_fault_masked,
  // Watched outputs
  input wire logic shutdown_indicator,
  input wire logic shutdown_irq,
  input wire pmsb_pkg::pmsb_rail_s controller_one_voltage
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence uv_taken;
    shutdown_evt.supply_uv && !reg_wr;
  endsequence
  sequence ind_clear;
    reg_wr && reg_addr == 8'h02 && reg_wdata[3];
  endsequence
  hot_read_a: assert property ( // status read
    reg_rd && reg_addr == 8'h04 && $stable(die_hot)
    |=> reg_rdata == {7'h00, $past(die_hot)}) else $error("bad status");
  cold_zero_a: assert property ( // upper bits zero
    reg_rd && reg_addr == 8'h05 |=> reg_rdata[7:3] == 5'h00)
    else $error("bad cause bits");
  uv_sets_a: assert property ( // indicator set
    uv_taken |=> shutdown_indicator) else $error("no indicator");
  masked_fault_a: assert property ( // masked fault ignored
    rail_fault_masked && shutdown_evt == 3'b010 && !shutdown_indicator
    |=> !shutdown_indicator) else $error("masked fault acted");
  irq_gate_a: assert property ( // irq follows indicator
    shutdown_irq |-> shutdown_indicator) else $error("stray irq");
  clear_hold_a: assert property ( // early clear refused
    uv_taken ##1 ind_clear |=> shutdown_indicator)
    else $error("indicator cleared early");
  code_write_a: assert property ( // code and decay
    reg_wr && reg_addr == 8'h20 |=> controller_one_voltage == $past(reg_wdata))
    else $error("bad controller write");
  rvalid_pulse_a: assert property ( // read answer timing
    reg_rd |=> reg_rvalid ##1 !reg_rvalid || $past(reg_rd))
    else $error("bad read pulse");
endmodule // pmsb_regs_asserts

bind pmsb_regs pmsb_regs_asserts u_chk (.clk, .nrst, .reg_addr, .reg_wr,
  .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid, .die_hot, .shutdown_evt,
  .rail_fault_masked, .shutdown_indicator, .shutdown_irq,
  .controller_one_voltage);

//--- verification/pmsb_host.sv
`timescale 1ns/10ps
module pmsb_host (
  // Clock
  input wire logic clk,
  // Register access
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
    // Released lines show the inverse so stale values never match
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
  endtask
endmodule // pmsb_host

//--- verification/tb_pmsb_regs.sv
`timescale 1ns/10ps
module tb_pmsb_regs;
  logic clk, nrst, die_hot, rail_fault_masked, reg_wr, reg_rd, reg_rvalid;
  logic one_coarse_range, two_coarse_range, shutdown_indicator, shutdown_irq;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d, controller_three_decay;
  logic [2:0] e;
  pmsb_pkg::pmsb_evt_s shutdown_evt;
  pmsb_pkg::pmsb_rail_s controller_one_voltage, controller_two_voltage;
  pmsb_pkg::pmsb_rail_out_s controller_one_rail, controller_two_rail;
  int fails, check_count;
  // Short slew step keeps the downward walk brief
  pmsb_regs #(.SLEW_STEP_CYC(2)) u_dut (.clk, .nrst, .reg_addr, .reg_wr,
    .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid, .die_hot, .shutdown_evt,
    .rail_fault_masked, .one_coarse_range, .two_coarse_range,
    .shutdown_indicator, .shutdown_irq, .controller_one_voltage,
    .controller_two_voltage, .controller_one_rail, .controller_two_rail,
    .controller_three_decay);
  pmsb_host u_host (.clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .reg_rvalid);
  task chk(input logic [11:0] seen, input logic [11:0] exp, input string n);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s exp %h seen %h", n, exp, seen);
    end
  endtask
  task end_sim;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    end_sim;
  end
  initial begin
    {nrst, die_hot, rail_fault_masked, one_coarse_range} = 4'h0;
    two_coarse_range = 1'b0;
    shutdown_evt = 3'h0;
    fails = 0;
    check_count = 0;
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    u_host.rd(8'h04, d); chk(d, 8'h00, "status");
    u_host.rd(8'h03, d); chk(d, 8'hff, "mask");
    u_host.rd(8'hb2, d); chk(d, 8'h00, "unmapped");
    rail_fault_masked = 1'b1;
    shutdown_evt = 3'b010;
    u_host.rd(8'h05, d); chk(d, 8'h00, "masked");
    shutdown_evt = 3'h0;
    rail_fault_masked = 1'b0;
    die_hot = 1'b1;
    u_host.wr(8'h04, 8'hfe);
    u_host.rd(8'h04, d); chk(d, 8'h01, "hot");
    for (int i = 0; i < 3; i++) begin
      e = 3'h1 << i;
      shutdown_evt = e;
      u_host.wr(8'h02, 8'h08);
      shutdown_evt = 3'h0;
      chk(shutdown_indicator, 1'b1, "ind");
      chk(shutdown_irq, 1'b0, "irq masked");
      u_host.rd(8'h05, d); chk(d, e, "cause");
      u_host.wr(8'h05, 8'h00);
      u_host.rd(8'h05, d); chk(d, e, "keep");
      u_host.wr(8'h05, 8'hff);
      u_host.rd(8'h05, d); chk(d, 8'h00, "clr");
      u_host.wr(8'h02, 8'h08);
      chk(shutdown_indicator, 1'b0, "ind clr");
    end
    fork
      u_host.wr(8'h05, 8'h04);
      begin
        @(negedge clk) shutdown_evt = 3'b100;
        @(negedge clk) shutdown_evt = 3'h0;
      end
    join
    u_host.rd(8'h05, d); chk(d, 8'h04, "set wins");
    u_host.wr(8'h03, 8'h00);
    u_host.rd(8'h03, d); chk(d, 8'h76, "mask");
    chk(shutdown_irq, 1'b1, "irq");
    u_host.wr(8'h05, 8'hff);
    u_host.wr(8'h02, 8'h08);
    one_coarse_range = 1'b1;
    u_host.wr(8'h20, 8'h52);
    u_host.rd(8'h20, d); chk(d, 8'h52, "ctl1");
    chk(controller_one_rail.out_mv, 12'h401, "mv1");
    u_host.wr(8'h21, 8'h0a);
    u_host.rd(8'h21, d); chk(d, 8'h0a, "ctl2");
    chk(controller_two_rail.out_mv, 12'h032, "mv2");
    chk(controller_two_voltage, 8'h0a, "ctl2 out");
    u_host.wr(8'h20, 8'h11);
    repeat (3) @(negedge clk);
    chk(controller_one_rail.applied_code, 7'h08, "decay");
    u_host.wr(8'h20, 8'h52);
    repeat (3) @(negedge clk);
    u_host.wr(8'h20, 8'h4e);
    repeat (2) @(negedge clk);
    chk(controller_one_rail.slewing, 1'b1, "slew");
    repeat (20) @(negedge clk);
    chk(controller_one_rail.applied_code, 7'h27, "slew end");
    u_host.wr(8'h22, 8'ha5);
    chk(controller_three_decay, 8'ha5, "ctl3 out");
    u_host.rd(8'h22, d); chk(d, 8'ha5, "ctl3");
    end_sim;
  end
endmodule // tb_pmsb_regs
